// File: lil_pkg.sv
// shared constants for the latching indicator led logic
package lil_pkg;
  // device clock and timing
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned BLINK_HALF_MS    = 250;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * (CLK_HZ / 1000);
  // geometry
  localparam int unsigned LEDS_PER_GROUP   = 8;
  localparam int unsigned NUM_LEDS         = 2 * LEDS_PER_GROUP;
  localparam int unsigned NUM_SLOTS        = 5;
  localparam int unsigned NUM_SIGS         = 32;
  localparam int unsigned SEL_W            = 6;
  // register byte offsets and group page numbers
  localparam logic [11:0] CTRL_OFS         = 12'h000;
  localparam logic [11:0] LATCH_STAT_OFS   = 12'h004;
  localparam logic [11:0] ACTIVE_STAT_OFS  = 12'h008;
  localparam logic [3:0]  GROUP_A_PAGE     = 4'h1;
  localparam logic [3:0]  GROUP_B_PAGE     = 4'h2;
  // ctrl fields
  localparam int unsigned CTRL_REMOTE_BIT  = 0;
  localparam int unsigned CTRL_GSRC_LSB    = 8;
  localparam int unsigned CTRL_COMM_BIT    = 16;
  // per-led config word 1 fields
  localparam int unsigned CFG_INV_LSB      = 0;
  localparam int unsigned CFG_MODE_LSB     = 5;
  localparam int unsigned CFG_ON_LSB       = 8;
  localparam int unsigned CFG_OFF_LSB      = 12;
  localparam int unsigned CFG_ACK_LSB      = 16;
  // reset values
  localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
  localparam logic [31:0] CFG_RST          = 32'h0000_0000;
  // latch modes
  localparam logic [1:0]  MODE_OFF         = 2'h0;
  localparam logic [1:0]  MODE_ON          = 2'h1;
  localparam logic [1:0]  MODE_ALARM       = 2'h2;
  // appearances
  typedef enum logic [2:0] {
    APP_DARK      = 3'h0,
    APP_GREEN     = 3'h1,
    APP_RED       = 3'h2,
    APP_RED_FLASH = 3'h3,
    APP_GRN_FLASH = 3'h4
  } lil_app_e;
endpackage

// File: lil_top.sv
// latching indicator led logic with wishbone register slave
//
// The Wishbone register port and the register addresses were decided locally.
module lil_top #(
  parameter int unsigned BLINK_CYC = lil_pkg::BLINK_HALF_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        RET_ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [31:0] SIG_IN,
  input  wire logic        PANEL_CLEAR_KEY,
  input  wire logic        PROT_ALARM,
  input  wire logic        BOOT_DONE,
  input  wire logic        PROT_ACTIVE,
  input  wire logic        INTERNAL_FAULT,
  output logic      [15:0] LED_GREEN,
  output logic      [15:0] LED_RED,
  output logic             SYS_OK_GREEN,
  output logic             SUPERVISION_CONTACT
);
  import lil_pkg::*;

  // overview of the datapath, one led at a time:
  //   - five slots each pick one trigger line, or none
  //   - a picked line may be inverted; an empty slot never can
  //   - the slots are or-ed into one combined trigger per led
  //   - a latching led remembers that the combination was seen
  //   - the shown state selects the on or the off appearance
  //   - the appearance maps to green and red with a blink phase
  // every led of both groups is the same hardware; the groups
  // differ only in which page of the map holds their setup.
  //
  // clear causes are all folded into one event per led, and the
  // latch only lets go while its combination is quiet. a cause
  // that only pulses while triggers still stand is simply lost, so
  // software must acknowledge again after the fault drops out.
  //
  // the latches, the led setup and ctrl sit behind the retention
  // reset, so a warm restart on the main reset keeps them. only
  // the display flops, the bus, the health outputs, the blink timer and the key, trigger and comm edge flops restart.
  //
  // acknowledge lines are edge sensitive: each is compared with
  // its value one cycle back. a line held high acknowledges once,
  // which keeps a stuck source from hiding every new latch.
  //
  // the panel key is the only pin here; it is synchronised. all
  // other inputs come from logic on this clock and are used raw.

  // pick one signal by 1-based select, zero when unassigned
  function automatic logic pick(input logic [SEL_W-1:0] sel,
                                input logic [31:0] vec);
    logic [SEL_W-1:0] idx;
    idx = sel - 6'h01;
    pick = (sel != 6'h00) && (sel <= 6'h20) ? vec[idx[4:0]] : 1'b0;
  endfunction

  // map appearance plus blink phase to green and red drive
  function automatic logic [1:0] paint(input logic [2:0] app,
                                       input logic ph);
    paint = 2'b00;
    case (app)
      APP_GREEN:     paint = 2'b10;
      APP_RED:       paint = 2'b01;
      APP_RED_FLASH: paint = {1'b0, ph};
      APP_GRN_FLASH: paint = {ph, 1'b0};
      default:       paint = 2'b00;
    endcase
  endfunction

  // reset synchronisers: warm restart and retention power-up
  logic [1:0] rst_sync_reg;
  logic [1:0] ret_sync_reg;
  logic       rst_n;
  logic       ret_n;

  // release both resets through two flops
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) rst_sync_reg <= 2'b00;
    else         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // retention domain only resets at true power-up
  always_ff @(posedge CLOCK or negedge RET_ARST_N) begin
    if (!RET_ARST_N) ret_sync_reg <= 2'b00;
    else             ret_sync_reg <= {ret_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];
  assign ret_n = ret_sync_reg[1];

  // panel key pin synchroniser and edge detect
  logic [1:0] key_sync_reg;
  logic       key_last_reg;
  logic       key_pulse;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_sync_reg <= 2'b00;
      key_last_reg <= 1'b0;
    end else begin
      key_sync_reg <= {key_sync_reg[0], PANEL_CLEAR_KEY};
      key_last_reg <= key_sync_reg[1];
    end
  end

  assign key_pulse = key_sync_reg[1] & ~key_last_reg;

  // previous trigger vector for ack edge detection
  logic [31:0] sig_last_reg;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) sig_last_reg <= 32'h0000_0000;
    else         sig_last_reg <= SIG_IN;
  end

  // bus decode
  logic        bus_req;
  logic        wr_go;
  logic        ack_reg;
  logic [31:0] wmask;
  logic [3:0]  page;
  logic        page_ok;
  logic [3:0]  led_idx;
  logic        cfg_hit;
  logic        ctrl_hit;
  logic        lstat_hit;
  logic        astat_hit;

  // map shape:
  //   page 0 holds ctrl, the latch states and the live states
  //   page 1 holds group a, page 2 holds group b
  //   within a group page each led owns eight bytes:
  //     word 0 the five slot selects, word 1 the led controls
  // writes land on the edge that first sees the request; the ack
  // rises on that same edge, so the ~ack_reg term stops a second
  // write while the master is still holding the same request.
  // unmapped offsets answer like any other, read zero and ignore
  // writes, so a stray access never stalls the bus.
  assign bus_req   = WB_CYC_I & WB_STB_I;
  assign wr_go     = bus_req & WB_WE_I & ~ack_reg;
  assign wmask     = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                      {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign page      = WB_ADR_I[11:8];
  // both groups share one map shape, only the page differs
  assign page_ok   = (page == GROUP_A_PAGE) | (page == GROUP_B_PAGE);
  assign led_idx   = {page == GROUP_B_PAGE, WB_ADR_I[5:3]};
  assign cfg_hit   = page_ok & (WB_ADR_I[7:6] == 2'b00);
  assign ctrl_hit  = WB_ADR_I == CTRL_OFS;
  assign lstat_hit = WB_ADR_I == LATCH_STAT_OFS;
  assign astat_hit = WB_ADR_I == ACTIVE_STAT_OFS;

  // control register and one-cycle communication ack
  logic [31:0] ctrl_reg;
  logic        comm_ack_reg;
  logic        remote_en;
  logic [5:0]  gsrc;
  logic        gack_pulse;

  // ctrl lives in the retention domain with the led setup
  always_ff @(posedge CLOCK or negedge RET_ARST_N) begin
    if (!RET_ARST_N) ctrl_reg <= CTRL_RST;
    else if (!ret_n) ctrl_reg <= CTRL_RST;
    else if (wr_go && ctrl_hit)
      ctrl_reg <= (ctrl_reg & ~wmask) | (WB_DAT_I & wmask);
  end

  // write of the comm bit fires one acknowledge pulse
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) comm_ack_reg <= 1'b0;
    else comm_ack_reg <= wr_go & ctrl_hit & WB_SEL_I[2] &
                         WB_DAT_I[CTRL_COMM_BIT];
  end

  assign remote_en  = ctrl_reg[CTRL_REMOTE_BIT];
  assign gsrc       = ctrl_reg[CTRL_GSRC_LSB +: SEL_W];
  // global source edge and comm command gated by remote enable
  assign gack_pulse = remote_en & ((pick(gsrc, SIG_IN) &
                      ~pick(gsrc, sig_last_reg)) | comm_ack_reg);

  // per-led configuration storage
  logic [31:0] cfg_asg_reg [NUM_LEDS];
  logic [31:0] cfg_ctl_reg [NUM_LEDS];
  logic [15:0] latch_reg;
  logic [15:0] active;
  logic [15:0] shown;

  // blink timebase shared by every flashing led
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == BLINK_CYC - 1) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  // per-led datapath, identical for both groups
  // the loop below builds sixteen copies of:
  //   slot pick and invert, combination, latch, appearance,
  //   colour mapping and the two output flops
  // priority inside the latch: retention reset, then set while
  // the combination is active in a latching mode, then clear.
  // set winning means a clear and a new trigger in one cycle
  // leave the led latched, which is the safe way round.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
      logic [4:0] slot_on;
      logic [1:0] mode;
      logic [5:0] ack_sel;
      logic       own_ack;
      logic       clr_evt;
      logic       quiet;
      logic [1:0] col;
      logic [2:0] app;
      logic [4:0] slot_used; // slot holds a select in range

      // five slots, each picked then optionally inverted
      for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
        logic [5:0] ssel;
        assign ssel = cfg_asg_reg[gi][s*SEL_W +: SEL_W];
        // select zero or beyond the vector counts as unassigned
        assign slot_used[s] = (ssel != 6'h00) && (ssel <= 6'h20);
        // unassigned slot stays zero, inversion ignored
        assign slot_on[s] = !slot_used[s] ? 1'b0 :
          pick(ssel, SIG_IN) ^ cfg_ctl_reg[gi][CFG_INV_LSB + s];
      end

      assign active[gi] = |slot_on;
      assign mode    = cfg_ctl_reg[gi][CFG_MODE_LSB +: 2];
      assign ack_sel = cfg_ctl_reg[gi][CFG_ACK_LSB +: SEL_W];
      // own ack is only meaningful while latching
      assign own_ack = (mode != MODE_OFF) & pick(ack_sel, SIG_IN) &
                       ~pick(ack_sel, sig_last_reg);
      assign quiet   = ~active[gi];
      // all slots empty also leaves quiet set, so latch clears
      assign clr_evt = key_pulse | own_ack | gack_pulse |
                       ((mode == MODE_ALARM) & PROT_ALARM) |
                       (mode == MODE_OFF) |
                       (slot_used == 5'h00);

      // latch in the retention domain so restarts keep it
      always_ff @(posedge CLOCK or negedge RET_ARST_N) begin
        if (!RET_ARST_N) latch_reg[gi] <= 1'b0;
        else if (!ret_n) latch_reg[gi] <= 1'b0;
        else if (mode != MODE_OFF && active[gi])
          latch_reg[gi] <= 1'b1;
        else if (clr_evt && quiet)
          latch_reg[gi] <= 1'b0;
      end

      // non-latching leds show the live combination only
      assign shown[gi] = active[gi] |
                         (latch_reg[gi] & (mode != MODE_OFF));
      assign app = shown[gi] ? cfg_ctl_reg[gi][CFG_ON_LSB +: 3]
                             : cfg_ctl_reg[gi][CFG_OFF_LSB +: 3];
      assign col = paint(app, blink_reg);

      // drive the bicolour led from flops
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          LED_GREEN[gi] <= 1'b0;
          LED_RED[gi]   <= 1'b0;
        end else begin
          LED_GREEN[gi] <= col[1];
          LED_RED[gi]   <= col[0];
        end
      end

      // configuration writes, kept across warm restarts
      always_ff @(posedge CLOCK or negedge RET_ARST_N) begin
        if (!RET_ARST_N) begin
          cfg_asg_reg[gi] <= CFG_RST;
          cfg_ctl_reg[gi] <= CFG_RST;
        end else if (!ret_n) begin
          cfg_asg_reg[gi] <= CFG_RST;
          cfg_ctl_reg[gi] <= CFG_RST;
        end else if (wr_go && cfg_hit && led_idx == gi) begin
          if (WB_ADR_I[2])
            cfg_ctl_reg[gi] <= (cfg_ctl_reg[gi] & ~wmask) |
                               (WB_DAT_I & wmask);
          else
            cfg_asg_reg[gi] <= (cfg_asg_reg[gi] & ~wmask) |
                               (WB_DAT_I & wmask);
        end
      end
    end
  endgenerate

  // read mux, unmapped addresses read zero
  logic [31:0] rd_cfg;
  logic [31:0] rd_data;

  assign rd_cfg  = WB_ADR_I[2] ? cfg_ctl_reg[led_idx] : cfg_asg_reg[led_idx];
  assign rd_data = ctrl_hit  ? {ctrl_reg[31:17], 1'b0, ctrl_reg[15:0]} :
                   lstat_hit ? {16'h0000, latch_reg} :
                   astat_hit ? {16'h0000, active} :
                   cfg_hit   ? rd_cfg : 32'h0000_0000;

  // single-wait classic cycle: ack one edge after the strobe
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_reg  <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req & ~ack_reg;
      WB_DAT_O <= rd_data;
    end
  end

  assign WB_ACK_O = ack_reg;

  // fixed system ok led and supervision contact
  logic healthy;

  assign healthy = BOOT_DONE & PROT_ACTIVE;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      SYS_OK_GREEN        <= 1'b0;
      SUPERVISION_CONTACT <= 1'b0;
    end else if (!rst_n) begin
      SYS_OK_GREEN        <= 1'b0;
      SUPERVISION_CONTACT <= 1'b0;
    end else begin
      // flash while booting, steady once protection runs
      SYS_OK_GREEN        <= healthy | blink_reg;
      SUPERVISION_CONTACT <= healthy & ~INTERNAL_FAULT;
    end
  end
endmodule // lil_top

// File: lil_props.sv
// port checker for the latching indicator led logic, bound to its top
module lil_props #(
  parameter int unsigned BLINK_CYC = 4 // blink half period of the top
) (
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  input wire logic        RET_ARST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        BOOT_DONE,
  input wire logic        PROT_ACTIVE,
  input wire logic        INTERNAL_FAULT,
  input wire logic [15:0] LED_GREEN,
  input wire logic [15:0] LED_RED,
  input wire logic        SYS_OK_GREEN,
  input wire logic        SUPERVISION_CONTACT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       rst_n;   // either reset parks the checker
  logic       req;     // fresh bus request
  logic       healthy; // booted, protecting, reset copy settled
  logic [2:0] rel_cnt; // edges since release, saturating
  assign rst_n   = ARST_N & RET_ARST_N;
  assign req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign healthy = (rel_cnt == 3'h4) & BOOT_DONE & PROT_ACTIVE;
  // wait out the two-flop release before judging health outputs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt <= 3'h0;
    end else if (rel_cnt != 3'h4) begin
      rel_cnt <= rel_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);
  property p_ack_next; req |=> WB_ACK_O; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rd_comm; req && !WB_WE_I && WB_ADR_I == 12'h0 |=> !WB_DAT_O[16];
  endproperty
  a_rd_comm: assert property (p_rd_comm) else $error("comm bit read 1");
  property p_colour; (LED_GREEN & LED_RED) == 16'h0; endproperty
  a_colour: assert property (p_colour) else $error("two colours");
  property p_sc_fault; INTERNAL_FAULT |=> !SUPERVISION_CONTACT; endproperty
  a_sc_fault: assert property (p_sc_fault) else $error("contact on fault");
  property p_sc_boot; !BOOT_DONE |=> !SUPERVISION_CONTACT; endproperty
  a_sc_boot: assert property (p_sc_boot) else $error("contact in boot");
  property p_sc_on; healthy && !INTERNAL_FAULT |-> ##[1:2] SUPERVISION_CONTACT;
  endproperty
  a_sc_on: assert property (p_sc_on) else $error("contact stays off");
  property p_ok_on; healthy |-> ##[1:2] SYS_OK_GREEN; endproperty
  a_ok_on: assert property (p_ok_on) else $error("sys ok not steady");
  c_contact: cover property (SUPERVISION_CONTACT);
  c_write: cover property (WB_ACK_O && WB_WE_I);
  c_red: cover property (LED_RED != 16'h0);
endmodule // lil_props
bind lil_top lil_props #(.BLINK_CYC(BLINK_CYC)) u_props (.*);

// File: lil_panel_model.sv
// front panel lamp and supervision relay, seen from outside the block
module lil_panel_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       lamp_red,
  input  wire logic       lamp_grn,
  input  wire logic       coil,
  output logic      [7:0] red_tgl,
  output logic      [7:0] grn_tgl,
  output logic            red_lit,
  output logic            relay_closed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic r_q; // red lamp one cycle back
  logic g_q; // green lamp one cycle back
  // lamps counted per window; the armature just follows its coil
  always @(posedge clk) begin
    r_q <= lamp_red;
    g_q <= lamp_grn;
    red_tgl <= clr ? 8'h0 : red_tgl + 8'(lamp_red ^ r_q);
    grn_tgl <= clr ? 8'h0 : grn_tgl + 8'(lamp_grn ^ g_q);
    red_lit <= ~clr & (red_lit | lamp_red);
    relay_closed <= coil;
  end
endmodule // lil_panel_model

// File: tb_latching_indicator_led_logic.sv
// self-checking bench for the latching indicator led logic
module tb_latching_indicator_led_logic;
  import lil_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK = 1'b0, ARST_N = 1'b0, RET_ARST_N = 1'b0;
  logic        WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic [11:0] WB_ADR_I = 12'h0;
  logic [3:0]  WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_I = 32'h0, SIG_IN = 32'h0, WB_DAT_O, rd, asg;
  logic        WB_ACK_O, PANEL_CLEAR_KEY = 1'b0, PROT_ALARM = 1'b0;
  logic        BOOT_DONE = 1'b0, PROT_ACTIVE = 1'b0, INTERNAL_FAULT = 1'b0;
  logic [15:0] LED_GREEN, LED_RED;
  logic        SYS_OK_GREEN, SUPERVISION_CONTACT, e, o, mclr = 1'b1;
  logic        red_lit, relay_closed;
  logic [7:0]  red_tgl, grn_tgl;
  logic [2:0]  a;
  logic [31:0] rng = 32'h5d;
  int          fail_count = 0, samples_checked = 0, n, t = 0;
  lil_top #(.BLINK_CYC(4)) uut (.*);
  lil_panel_model lamp0 (.clk(CLOCK), .clr(mclr), .lamp_red(LED_RED[0]),
    .lamp_grn(LED_GREEN[0]), .coil(SUPERVISION_CONTACT), .red_tgl(red_tgl),
    .grn_tgl(grn_tgl), .red_lit(red_lit), .relay_closed(relay_closed));
  always #50 CLOCK = ~CLOCK;
  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // expected or of five slots; selects outside 1..32 give zero
  function automatic logic comb(input logic [31:0] sl, input logic [4:0] iv,
                                input logic [31:0] s);
    logic       c;
    logic [5:0] q;
    c = 1'b0;
    for (int k = 0; k < 5; k++) begin
      q = sl[6*k +: 6];
      if (q != 6'h0 && q <= 6'h20) c = c | (s[q - 6'h1] ^ iv[k]);
    end
    return c;
  endfunction
  // control word: invert, mode, on and off look, own clear on input 1
  function automatic logic [31:0] cf(input logic [4:0] iv,
      input logic [1:0] md, input logic [2:0] on, input logic [2:0] off);
    return {10'h0, 6'h2, 1'b0, off, 1'b0, on, 1'b0, md, iv};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, expv);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask
  // settle point for checks, away from the edge
  task automatic nx(input int k);
    cyc(k);
    @(negedge CLOCK);
  endtask
  task automatic sg(input logic [31:0] v);
    @(posedge CLOCK);
    SIG_IN <= v;
  endtask
  // one classic cycle; held until ack is sampled
  task automatic wb(input logic we, input logic [11:0] ad,
                    input logic [31:0] d);
    @(posedge CLOCK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= ad;
    WB_DAT_I <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge CLOCK);
      if (WB_ACK_O === 1'b1) break;
    end
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    if (n == 20) begin
      fail_count++;
      end_sim();
    end
  endtask
  // one clearing cause per code, held four cycles
  task automatic clr(input int k);
    @(posedge CLOCK);
    case (k)
      0: PANEL_CLEAR_KEY <= 1'b1;
      1: SIG_IN <= SIG_IN | 32'h2;
      2, 5: SIG_IN <= SIG_IN | 32'h4;
      3, 6: wb(1'b1, CTRL_OFS, k == 3 ? 32'h1_0301 : 32'h1_0300);
      4: PROT_ALARM <= 1'b1;
      7: wb(1'b1, 12'h104, cf(5'h0, 2'h0, 3'h2, 3'h1));
      8: wb(1'b1, 12'h100, 32'h0);
      default: ARST_N <= 1'b0;
    endcase
    cyc(4);
    PANEL_CLEAR_KEY <= 1'b0;
    PROT_ALARM <= 1'b0;
    ARST_N <= 1'b1;
    SIG_IN <= SIG_IN & 32'h1;
  endtask
  initial begin
    cyc(4);
    ARST_N <= 1'b1;
    RET_ARST_N <= 1'b1;
    o = 1'b0;
    repeat (30) begin
      @(posedge CLOCK);
      t += int'(SYS_OK_GREEN !== o);
      o = SYS_OK_GREEN;
    end
    @(negedge CLOCK);
    chk(t > 3, 1'b1);
    chk(relay_closed, 1'b0);
    cyc(1);
    BOOT_DONE <= 1'b1;
    PROT_ACTIVE <= 1'b1;
    nx(5);
    chk(SYS_OK_GREEN, 1'b1);
    chk(relay_closed, 1'b1);
    cyc(1);
    INTERNAL_FAULT <= 1'b1;
    nx(3);
    chk(relay_closed, 1'b0);
    cyc(1);
    INTERNAL_FAULT <= 1'b0;
    $display("test boot done");
    // random selects and inversions on one led of each group
    for (int j = 0; j < 24; j++) begin
      asg = xs();
      wb(1'b1, 12'h100, asg);
      wb(1'b1, 12'h104, cf(asg[31:27], 2'h0, 3'h2, 3'h1));
      wb(1'b1, 12'h200, asg);
      wb(1'b1, 12'h204, cf(asg[31:27], 2'h0, 3'h2, 3'h1));
      sg(xs());
      nx(1);
      e = comb(asg, asg[31:27], SIG_IN);
      chk(LED_RED[0], e);
      chk(LED_GREEN[0], !e);
      chk(LED_RED[8], e);
      wb(1'b0, ACTIVE_STAT_OFS, 32'h0);
      chk(rd[8], e);
    end
    $display("test random triggers done");
    wb(1'b1, 12'h100, 32'h1);
    // every look, shown as on look then as off look
    for (int j = 0; j < 10; j++) begin
      a = 3'(j % 5);
      wb(1'b1, 12'h104, cf(5'h0, 2'h0, a, a));
      sg({31'h0, j < 5});
      cyc(2);
      mclr <= 1'b0;
      nx(40);
      chk(red_tgl > 6, a == 3'h3);
      chk(grn_tgl > 6, a == 3'h4);
      chk(red_lit, a == 3'h2 || a == 3'h3);
      cyc(1);
      mclr <= 1'b1;
    end
    $display("test appearances done");
    // latch set, refused clear while active, then each cause clears it, except remote off and warm restart which keep it
    for (int k = 0; k < 10; k++) begin
      wb(1'b1, CTRL_OFS, (k == 5 || k == 6) ? 32'h300 : 32'h301);
      wb(1'b1, 12'h104, cf(5'h0, k == 4 ? 2'h2 : 2'h1, 3'h2, 3'h1));
      sg(32'h1);
      clr(k);
      nx(3);
      chk(LED_RED[0], k != 8);
      sg(32'h0);
      nx(3);
      chk(LED_RED[0], k != 7 && k != 8);
      clr(k);
      nx(3);
      e = !(k == 5 || k == 6 || k == 9);
      chk(LED_RED[0], !e);
      wb(1'b0, LATCH_STAT_OFS, 32'h0);
      chk(rd[0], !e && k != 7);
      wb(1'b1, 12'h100, 32'h1);
      wb(1'b1, CTRL_OFS, 32'h1_0301);
    end
    $display("test latching done");
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h301);
    wb(1'b0, 12'hffc, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    end_sim();
  end
endmodule // tb_latching_indicator_led_logic
